// [core/vpic_ctrl.sv]
// Vectored priority interrupt controller with classic Wishbone registers.
// Assumes sources, traps and core handshake are on ref_clk; the core acks
// the request and later reports its return with the restored level.
// Summary of operation
// R1: All pending requests merge into one core request
// R2: Default table at 0x4, 126 vectors
// R3: Each vector yields a 24-bit address
// R4: Alternate select bit moves all fetches
// R5: Alternate table sits 0x100 above default
// R6: Traps vectors 1 to 4, sources from 8
// R7: Reset clears registers; controller plays no part
// R8: Taken only when strictly above core level
// R9: Levels 8 to 15 belong to traps
// R10: Each trap has its own fixed level
// R11: Source level 0 means disabled
// R12: Core level is field plus upper bit
// R13: Level field writable, masks at or below
// R14: Field at seven blocks every user source
// R15: Upper bit set by traps, software clears only
// R16: Nesting disabled makes level field read-only
// R17: Three bits per nibble, bit 3 zero
// R18: User levels 1 to 7, shareable
// R19: Level first, then lower vector wins
// R20: Only higher level preempts running exception
// R21: Math trap level 11, stack 12
// R22: Soft traps sampled two cycles later
// R23: Present vector, level; ack raises core level
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ns
module vpic_ctrl
  import vpic_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Request sources
  input  wire logic [NUM_SRC-1:0]   src_req,
  input  wire logic [NUM_TRAP-1:0]  trap_req,
  // Core handshake
  output logic                      core_irq,
  output logic      [VEC_W-1:0]     core_vec_num,
  output logic      [ADDR_W-1:0]    core_vec_addr,
  output logic      [LVL_W-1:0]     core_irq_lvl,
  output logic      [LVL_W-1:0]     core_lvl,
  input  wire logic                 core_ack,
  input  wire logic                 core_ret,
  input  wire logic [LVL_W-1:0]     core_ret_lvl
);

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  logic                   ack_ff;
  logic                   acc;
  logic                   wr;
  logic [UPRIO_W-1:0]     prio_ff [NUM_SRC];
  logic [NUM_SRC*UPRIO_W-1:0] prio_flat;
  logic                   alt_sel_ff;
  logic                   nest_dis_ff;
  logic [LVL_W-1:0]       cur_lvl_ff;
  logic [LVL_W-1:0]       nxt_cur_lvl;
  logic [NUM_TRAP-1:0]    trap_s1_ff;
  logic [NUM_TRAP-1:0]    trap_s2_ff;
  logic [NUM_TRAP-1:0]    trap_eff;
  logic                   win_valid;
  logic [LVL_W-1:0]       win_lvl;
  logic [VEC_W-1:0]       win_vec;
  logic                   req_ff;
  logic [VEC_W-1:0]       vec_ff;
  logic [LVL_W-1:0]       lvl_ff;
  logic [ADDR_W-1:0]      addr_ff;
  logic [ADDR_W-1:0]      nxt_addr;
  logic [VEC_W-1:0]       act_ff;
  logic                   taken;
  logic [31:0]            nxt_rdata;
  logic [31:0]            rdata_ff;

  // Bus access: one access per request, ack one cycle after the strobe
  assign acc   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr    = acc & wb_we_i;
  assign taken = core_ack & req_ff;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= acc;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Per-source priority nibbles
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_prio
      localparam logic [7:0] WADR = OFS_PRIO + 8'((gi / 8) * 4);
      localparam int         NIB  = gi % 8;

      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
          prio_ff[gi] <= PRIO_RST; // R7
        else if (wr && hit(wb_adr_i, WADR) && wb_sel_i[NIB/2])
          prio_ff[gi] <= wb_dat_i[NIB*4 +: UPRIO_W]; // R17 R18
      end

      assign prio_flat[gi*UPRIO_W +: UPRIO_W] = prio_ff[gi];
    end
  endgenerate

  // Second control register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alt_sel_ff  <= 1'b0;
      nest_dis_ff <= 1'b0;
    end
    else if (wr && hit(wb_adr_i, OFS_CTL2) && wb_sel_i[1])
    begin
      alt_sel_ff  <= wb_dat_i[ALT_SEL_BIT];
      nest_dis_ff <= wb_dat_i[NEST_DIS_BIT];
    end
  end

  // Core level: core entry wins, then return, then software
  always_comb
  begin
    nxt_cur_lvl = cur_lvl_ff;
    if (taken)
      nxt_cur_lvl = lvl_ff; // R23 R15
    else if (core_ret)
      nxt_cur_lvl = core_ret_lvl;
    else
    begin
      if (wr && hit(wb_adr_i, OFS_STAT) && wb_sel_i[0] && !nest_dis_ff) // R16
        nxt_cur_lvl[2:0] = wb_dat_i[LVL_LSB +: 3]; // R13
      if (wr && hit(wb_adr_i, OFS_CCTL) && wb_sel_i[0])
        nxt_cur_lvl[3] = cur_lvl_ff[3] & wb_dat_i[UP_BIT]; // R15
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cur_lvl_ff <= LVL_RST; // R7
    else
      cur_lvl_ff <= nxt_cur_lvl; // R12
  end

  assign core_lvl = cur_lvl_ff;

  // Trap sampling: hard traps one stage, soft traps two
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trap_s1_ff <= '0;
      trap_s2_ff <= '0;
    end
    else
    begin
      trap_s1_ff <= trap_req;
      trap_s2_ff <= trap_s1_ff & trap_req; // R22
    end
  end

  assign trap_eff = (trap_s1_ff & ~SOFT_TRAP_MASK)
                  | (trap_s2_ff & trap_s1_ff & SOFT_TRAP_MASK); // R21 R22

  vpic_resolve u_resolve
  (
    .src_req   (src_req),
    .src_lvl   (prio_flat),
    .trap_req  (trap_eff),
    .win_valid (win_valid),
    .win_lvl   (win_lvl),
    .win_vec   (win_vec)
  );

  // Vector address from the selected table
  always_comb
  begin
    if (alt_sel_ff)
      nxt_addr = ALT_TABLE_BASE + ADDR_W'({win_vec, 1'b0}); // R4 R5
    else
      nxt_addr = DEF_TABLE_BASE + ADDR_W'({win_vec, 1'b0}); // R2 R3 R6
  end

  // Request to the core, held steady during the entry cycle
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      req_ff <= 1'b0;
    else
      req_ff <= win_valid && (win_lvl > nxt_cur_lvl) && !taken; // R1 R8 R14 R20
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vec_ff  <= '0;
      lvl_ff  <= LVL_RST;
      addr_ff <= RESET_PC;
    end
    else if (!taken)
    begin
      vec_ff  <= win_vec; // R23
      lvl_ff  <= win_lvl;
      addr_ff <= nxt_addr;
    end
  end

  assign core_irq      = req_ff;
  assign core_vec_num  = vec_ff;
  assign core_irq_lvl  = lvl_ff;
  assign core_vec_addr = addr_ff;

  // Last accepted vector, visible to software
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      act_ff <= '0;
    else if (taken)
      act_ff <= vec_ff;
  end

  // Read data; unmapped words read as zero
  always_comb
  begin
    int base;
    int idx;
    base      = 0;
    idx       = 0;
    nxt_rdata = '0;
    if (hit(wb_adr_i, OFS_CTL2))
    begin
      nxt_rdata[ALT_SEL_BIT]  = alt_sel_ff;
      nxt_rdata[NEST_DIS_BIT] = nest_dis_ff;
    end
    else if (hit(wb_adr_i, OFS_STAT))
      nxt_rdata[LVL_LSB +: 3] = cur_lvl_ff[2:0];
    else if (hit(wb_adr_i, OFS_CCTL))
      nxt_rdata[UP_BIT] = cur_lvl_ff[3];
    else if (hit(wb_adr_i, OFS_ACT))
      nxt_rdata[VEC_W-1:0] = act_ff;
    else if (wb_adr_i[7:2] >= OFS_PRIO[7:2]
             && int'(wb_adr_i[7:2]) < int'(OFS_PRIO[7:2]) + PRIO_WORDS)
    begin
      base = (int'(wb_adr_i[7:2]) - int'(OFS_PRIO[7:2])) * 8;
      for (int n = 0; n < 8; n++)
      begin
        idx = base + n;
        if (idx < NUM_SRC)
          nxt_rdata[n*4 +: UPRIO_W] = prio_ff[idx]; // R17
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= '0;
    else if (acc && !wb_we_i)
      rdata_ff <= nxt_rdata;
  end

endmodule // vpic_ctrl

// [core/vpic_pkg.sv]
// Constants shared by the interrupt controller and its priority resolver.
// Assumes one 100 MHz clock domain and a classic Wishbone register slave.
package vpic_pkg;

  // Source counts and widths
  localparam int NUM_SRC  = 118;
  localparam int NUM_TRAP = 4;
  localparam int VEC_W    = 7;
  localparam int LVL_W    = 4;
  localparam int UPRIO_W  = 3;
  localparam int ADDR_W   = 24;

  // Vector tables: two bytes per entry
  localparam logic [ADDR_W-1:0] DEF_TABLE_BASE = 24'h000004;
  localparam logic [ADDR_W-1:0] ALT_TABLE_BASE = 24'h000104;
  localparam logic [ADDR_W-1:0] RESET_PC       = 24'h000000;
  localparam logic [VEC_W-1:0]  SRC_VEC0       = 7'h08;

  // Trap order: 0 osc fail, 1 address, 2 stack, 3 math
  localparam logic [VEC_W-1:0] TRAP_VEC [NUM_TRAP] = '{7'h01, 7'h02, 7'h03, 7'h04};
  localparam logic [LVL_W-1:0] TRAP_LVL [NUM_TRAP] = '{4'he, 4'hd, 4'hc, 4'hb};
  localparam logic [NUM_TRAP-1:0] SOFT_TRAP_MASK   = 4'hc;

  // Register byte offsets
  localparam logic [7:0] OFS_CTL2  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_CCTL  = 8'h08;
  localparam logic [7:0] OFS_ACT   = 8'h0c;
  localparam logic [7:0] OFS_PRIO  = 8'h40;
  localparam int         PRIO_WORDS = 15;

  // Field positions
  localparam int ALT_SEL_BIT  = 15;
  localparam int NEST_DIS_BIT = 14;
  localparam int LVL_LSB      = 5;
  localparam int UP_BIT       = 3;

  // Reset values
  localparam logic [UPRIO_W-1:0] PRIO_RST = 3'h0;
  localparam logic [LVL_W-1:0]   LVL_RST  = 4'h0;

endpackage

// [core/vpic_resolve.sv]
// Combinational priority resolver: traps, then user level, then vector order.
// Assumes request inputs are already in the controller clock domain.
`timescale 1ns/1ns
module vpic_resolve
  import vpic_pkg::*;
(
  // Requests
  input  wire logic [NUM_SRC-1:0]         src_req,
  input  wire logic [NUM_SRC*UPRIO_W-1:0] src_lvl,
  input  wire logic [NUM_TRAP-1:0]        trap_req,
  // Winner
  output logic                            win_valid,
  output logic [LVL_W-1:0]                win_lvl,
  output logic [VEC_W-1:0]                win_vec
);

  always_comb
  begin
    logic [UPRIO_W-1:0] l;
    l         = '0;
    win_valid = 1'b0;
    win_lvl   = '0;
    win_vec   = '0;
    // Walk downward so the lowest vector wins a tie
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      l = src_lvl[i*UPRIO_W +: UPRIO_W];
      if (src_req[i] && l != '0 && {1'b0, l} >= win_lvl) // R11 R19
      begin
        win_valid = 1'b1;
        win_lvl   = {1'b0, l};
        win_vec   = SRC_VEC0 + VEC_W'(i);
      end
    end
    // Fixed trap levels all sit above any user level
    for (int t = NUM_TRAP - 1; t >= 0; t--)
    begin
      if (trap_req[t] && TRAP_LVL[t] >= win_lvl) // R9 R10
      begin
        win_valid = 1'b1;
        win_lvl   = TRAP_LVL[t];
        win_vec   = TRAP_VEC[t];
      end
    end
  end

endmodule // vpic_resolve

// [verif/vpic_ctrl_assertions.sv]
// Checker for the interrupt controller top ports.
// Assumes one clock domain; bound to every vpic_ctrl instance.
`timescale 1ns/1ns
module vpic_ctrl_chk
  import vpic_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              core_irq,
  input wire logic [VEC_W-1:0]  core_vec_num,
  input wire logic [ADDR_W-1:0] core_vec_addr,
  input wire logic [LVL_W-1:0]  core_irq_lvl,
  input wire logic [LVL_W-1:0]  core_lvl,
  input wire logic              core_ack,
  input wire logic              core_ret,
  input wire logic [LVL_W-1:0]  core_ret_lvl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [ADDR_W-1:0] ofs;
  assign ofs = {16'h0, core_vec_num, 1'b0};
  wb_ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  entry_level_a: assert property (core_ack && core_irq |=> core_lvl == $past(core_irq_lvl))
    else $error("entry level wrong");
  irq_drop_a: assert property (core_ack && core_irq |=> !core_irq)
    else $error("request not dropped");
  above_core_a: assert property (core_irq && $stable(core_lvl) |-> core_irq_lvl > core_lvl)
    else $error("request not above core level");
  vec_addr_a: assert property (core_irq |-> core_vec_addr == DEF_TABLE_BASE + ofs ||
    core_vec_addr == ALT_TABLE_BASE + ofs) else $error("vector address wrong");
  trap_band_a: assert property (core_irq |-> core_irq_lvl[3] == (core_vec_num < 7'h08))
    else $error("level band wrong");
  trap_fixed_a: assert property (core_irq && core_vec_num < 7'h08 |->
    core_irq_lvl == 4'hf - core_vec_num[3:0]) else $error("trap level wrong");
  ret_restore_a: assert property (core_ret && !core_ack |=> core_lvl == $past(core_ret_lvl))
    else $error("return level wrong");
  upper_set_a: assert property ($rose(core_lvl[3]) |-> $past(core_ack) || $past(core_ret))
    else $error("upper bit set by software");
  cover property (core_ack && core_irq);
  cover property (core_irq && core_vec_num < 7'h08);
  cover property (core_irq && core_vec_addr[8]);
endmodule // vpic_ctrl_chk

bind vpic_ctrl vpic_ctrl_chk chk_u (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .core_irq(core_irq), .core_vec_num(core_vec_num),
  .core_vec_addr(core_vec_addr), .core_irq_lvl(core_irq_lvl), .core_lvl(core_lvl),
  .core_ack(core_ack), .core_ret(core_ret), .core_ret_lvl(core_ret_lvl));

// [verif/vpic_core_model.sv]
// Behavioural core: accepts the request, later returns with the saved level.
// Assumes the bench gates acceptance and return to make it slow or prompt.
`timescale 1ns/1ns
module vpic_core_model
  import vpic_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             core_irq,
  input  wire logic [LVL_W-1:0] core_lvl,
  input  wire logic             ack_en,
  input  wire logic             ret_en,
  output logic                  core_ack,
  output logic                  core_ret,
  output logic [LVL_W-1:0]      core_ret_lvl
);
  logic pend_ff;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      core_ack <= 1'b0;
      core_ret <= 1'b0;
      pend_ff <= 1'b0;
      core_ret_lvl <= 4'h0;
    end
    else
    begin
      core_ack <= ack_en && core_irq && !core_ack;
      core_ret <= ret_en && pend_ff && !core_ret;
      if (core_ack && core_irq)
      begin
        pend_ff <= 1'b1;
        core_ret_lvl <= core_lvl;
      end
      else if (core_ret)
        pend_ff <= 1'b0;
    end
endmodule // vpic_core_model

// [verif/vpic_ctrl_bench.sv]
// Self-checking bench for the interrupt controller.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module vpic_ctrl_bench;
  import vpic_pkg::*;
  logic ref_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack_en = 0, ret_en = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, q, w;
  logic [117:0] src = 0;
  logic [3:0] trap = 0;
  logic [15:0] lfsr = 16'hd474;
  logic [2:0] pr [118];
  logic [2:0] cl;
  logic alt;
  wire [31:0] dat_o;
  wire ack, irq, cack, cret;
  wire [6:0] vec;
  wire [23:0] vadr;
  wire [3:0] ilvl, clvl, rlvl;
  int failures = 0, samples_checked = 0, k;
  always #5 ref_clk = ~ref_clk;
  vpic_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .src_req(src), .trap_req(trap), .core_irq(irq), .core_vec_num(vec),
    .core_vec_addr(vadr), .core_irq_lvl(ilvl), .core_lvl(clvl), .core_ack(cack),
    .core_ret(cret), .core_ret_lvl(rlvl));
  vpic_core_model core_u (.ref_clk(ref_clk), .resetn(resetn), .core_irq(irq),
    .core_lvl(clvl), .ack_en(ack_en), .ret_en(ret_en), .core_ack(cack), .core_ret(cret),
    .core_ret_lvl(rlvl));
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Winner by level, ties to the lower vector
  function logic [35:0] ex(input logic [117:0] r);
    logic [2:0] bl;
    int bv;
    bl = 0;
    bv = 0;
    for (int i = 117; i >= 0; i--)
      if (r[i] && pr[i] > cl && pr[i] >= bl)
      begin
        bl = pr[i];
        bv = i + 8;
      end
    if (bl == 0)
      return 36'h0;
    return {2'b10, bl, 7'(bv), (alt ? ALT_TABLE_BASE : DEF_TABLE_BASE) + 24'(2 * bv)};
  endfunction
  task chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w_en;
    adr <= a;
    dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge ref_clk);
  endtask
  task stop_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #50000;
    failures++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    chk(clvl, 0);
    foreach (pr[i]) pr[i] = 0;
    for (int a = 0; a < 16; a += 4)
    begin
      bus(0, 8'(a), 0);
      chk(q, 0);
    end
    for (int it = 0; it < 12; it++)
    begin
      k = rnd() % 14;
      w = {rnd(), rnd()};
      bus(1, OFS_PRIO + 8'(4 * k), w);
      for (int j = 0; j < 8; j++) pr[8 * k + j] = w[4 * j +: 3];
      bus(0, OFS_PRIO + 8'(4 * k), 0);
      chk(q, w & 32'h77777777);
      cl = (it == 0) ? 3'h7 : rnd() % 8;
      alt = rnd() % 2;
      bus(1, OFS_STAT, {cl, 5'h0});
      bus(0, OFS_STAT, 0);
      chk(q, {cl, 5'h0});
      bus(1, OFS_CTL2, {alt, 15'h0});
      src <= 118'(rnd() % 256) << (8 * k);
      repeat (3) @(posedge ref_clk);
      chk(irq ? {irq, ilvl, vec, vadr} : 36'h0, ex(src));
      src <= 0;
    end
    bus(1, OFS_STAT, 0);
    bus(1, OFS_CTL2, 0);
    bus(1, OFS_PRIO, 32'h77);
    trap <= 4'h8;
    src <= 1;
    repeat (4) @(posedge ref_clk);
    chk({irq, ilvl, vec, vadr}, {1'b1, 4'hb, 7'h04, 24'h00000c});
    ack_en <= 1;
    repeat (3) @(posedge ref_clk);
    ack_en <= 0;
    trap <= 0;
    src <= 0;
    chk(clvl, 4'hb);
    bus(0, OFS_ACT, 0);
    chk(q, 32'h4);
    bus(1, OFS_CCTL, 0);
    chk(clvl, 4'h3);
    bus(1, OFS_CCTL, 8);
    chk(clvl, 4'h3);
    bus(1, OFS_CTL2, 32'h4000);
    bus(1, OFS_STAT, 32'he0);
    chk(clvl, 4'h3);
    bus(1, OFS_CTL2, 0);
    ret_en <= 1;
    repeat (3) @(posedge ref_clk);
    ret_en <= 0;
    chk(clvl, 0);
    // Source 1 enters first; source 0 at the same level must then wait
    src <= 2;
    ack_en <= 1;
    repeat (3) @(posedge ref_clk);
    src <= 3;
    repeat (3) @(posedge ref_clk);
    chk({irq, clvl}, {1'b0, 4'h7});
    bus(0, OFS_ACT, 0);
    chk(q, 32'h9);
    // Reset in mid-run clears the level and the priorities
    ack_en <= 0;
    resetn <= 0;
    @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    chk({irq, clvl}, 5'h0);
    bus(0, OFS_PRIO, 0);
    chk(q, 0);
    stop_test();
  end
endmodule // vpic_ctrl_bench
